//--- src/msg_side_pkg.sv
// constants shared by the message side-channel block
// assumes a single 10 MHz user clock and an axi4-lite register port
package msg_side_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // transmit type codes
    localparam logic [2:0] TX_LTR  = 3'h0;
    localparam logic [2:0] TX_OBFF = 3'h1;
    localparam logic [2:0] TX_SSPL = 3'h2;
    localparam logic [2:0] TX_PME  = 3'h3;
    // ltr field positions
    localparam int unsigned LTR_SNOOP_REQ = 31;
    localparam int unsigned LTR_SNOOP_SCL_HI = 28;
    localparam int unsigned LTR_SNOOP_SCL_LO = 26;
    localparam int unsigned LTR_SNOOP_VAL_HI = 25;
    localparam int unsigned LTR_SNOOP_VAL_LO = 16;
    localparam int unsigned LTR_NOSNP_REQ = 15;
    localparam int unsigned LTR_NOSNP_SCL_HI = 12;
    localparam int unsigned LTR_NOSNP_SCL_LO = 10;
    localparam int unsigned LTR_NOSNP_VAL_HI = 9;
    localparam int unsigned OBFF_CODE_HI = 3;
    localparam int unsigned SSPL_HI = 9;
    localparam int unsigned PME_PF_HI = 1;
    localparam int unsigned PME_VF_HI = 9;
    localparam int unsigned PME_VF_LO = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_MASK      = 8'h08;
    localparam logic [7:0] OFS_RX_INJECT = 8'h0c;
    localparam logic [7:0] OFS_TX_LAST   = 8'h10;
    localparam logic [7:0] OFS_TX_DATA   = 8'h14;
    localparam logic [7:0] OFS_RX_LAST   = 8'h18;
    // status / mask bit positions
    localparam int unsigned ST_RX_DONE = 0;
    localparam int unsigned ST_TX_DONE = 1;
    localparam int unsigned ST_TX_BAD  = 2;
    localparam int unsigned ST_WIDTH   = 3;
    // ctrl bits
    localparam int unsigned CTRL_RX_EN = 0;
    localparam int unsigned CTRL_TX_EN = 1;
    // inject word fields: type in [4:0], byte count in [7:5], bytes from [15:8]
    localparam int unsigned INJ_CNT_LO = 5;
    localparam int unsigned INJ_CNT_HI = 7;
    localparam int unsigned INJ_BYTE_LO = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned TX_LAT_CYC = 2; // busy cycles before done; done comes 3 cycles after take
endpackage

//--- src/rx_msg_deliver.sv
// receive-side sequencer: plays one message out byte by byte
// assumes start is only raised while idle is high
`timescale 1ns/100ps
`default_nettype none
module rx_msg_deliver #(
    parameter int unsigned NBYTES = 3
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // request
    input  wire logic         start,
    input  wire logic [4:0]   msg_type,
    input  wire logic [2:0]   msg_cnt,
    input  wire logic [23:0]  msg_bytes,
    output logic              idle,
    // user side
    output logic              msg_arrived,
    output logic [7:0]        msg_param,
    output logic [4:0]        msg_kind
);
    typedef enum logic [1:0] {S_IDLE, S_SEND, S_GAP} rx_state_t;
    rx_state_t   state_reg, state_next;
    logic [2:0]  left_reg, left_next;
    logic [23:0] sh_reg, sh_next;
    logic [7:0]  par_reg, par_next;
    logic [4:0]  kind_reg, kind_next;
    logic        arr_reg, arr_next;

    // next state: one byte per cycle, then a forced low cycle
    always_comb begin
        state_next = state_reg;
        left_next  = left_reg;
        sh_next    = sh_reg;
        par_next   = par_reg;
        kind_next  = kind_reg;
        arr_next   = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    kind_next  = msg_type;
                    par_next   = msg_bytes[7:0];
                    sh_next    = {8'h00, msg_bytes[23:8]};
                    left_next  = (msg_cnt == 3'h0) ? 3'h0 : msg_cnt - 3'h1;
                    arr_next   = 1'b1;
                    state_next = S_SEND;
                end
            end
            S_SEND: begin
                if (left_reg != 3'h0) begin
                    arr_next  = 1'b1;
                    par_next  = sh_reg[7:0];
                    sh_next   = {8'h00, sh_reg[23:8]};
                    left_next = left_reg - 3'h1;
                end else begin
                    state_next = S_GAP;
                end
            end
            S_GAP: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= S_IDLE;
            left_reg  <= 3'h0;
            sh_reg    <= 24'h000000;
            par_reg   <= 8'h00;
            kind_reg  <= 5'h00;
            arr_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            left_reg  <= left_next;
            sh_reg    <= sh_next;
            par_reg   <= par_next;
            kind_reg  <= kind_next;
            arr_reg   <= arr_next;
        end
    end

    assign idle        = (state_reg == S_IDLE);
    assign msg_arrived = arr_reg;
    assign msg_param   = par_reg;
    assign msg_kind    = kind_reg;

    a_rx_gap_after: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(arr_reg) |=> !arr_reg)
        else $error("arrival gap missing");
    a_rx_start_one: assert property (@(posedge aclk) disable iff (!aresetn)
        (start && idle) |=> arr_reg)
        else $error("arrival not raised after start");
endmodule // rx_msg_deliver
`default_nettype wire

//--- src/tx_msg_engine.sv
// transmit-side engine: takes a request, checks the type, pulses done
// assumes the requester holds request, type and data until done
`timescale 1ns/100ps
`default_nettype none
module tx_msg_engine (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        enable,
    // user request
    input  wire logic        tx_req,
    input  wire logic [2:0]  tx_type,
    input  wire logic [31:0] tx_data,
    output logic             tx_done,
    // results
    output logic             sent,
    output logic             bad_type,
    output logic [2:0]       last_type,
    output logic [31:0]      last_word
);
    typedef enum logic [1:0] {T_IDLE, T_BUSY, T_DONE} tx_state_t;
    tx_state_t   state_reg, state_next;
    logic [1:0]  cnt_reg, cnt_next;
    logic [2:0]  typ_reg, typ_next;
    logic [31:0] word_reg, word_next;
    logic        bad_reg, bad_next;

    // keep only the fields defined for each type
    function automatic logic [31:0] mask_fields(input logic [2:0] t, input logic [31:0] d);
        logic [31:0] m;
        m = 32'h00000000;
        case (t)
            msg_side_pkg::TX_LTR: begin
                m[msg_side_pkg::LTR_SNOOP_REQ] = d[msg_side_pkg::LTR_SNOOP_REQ];
                m[msg_side_pkg::LTR_SNOOP_SCL_HI:msg_side_pkg::LTR_SNOOP_SCL_LO] =
                    d[msg_side_pkg::LTR_SNOOP_SCL_HI:msg_side_pkg::LTR_SNOOP_SCL_LO];
                m[msg_side_pkg::LTR_SNOOP_VAL_HI:msg_side_pkg::LTR_SNOOP_VAL_LO] =
                    d[msg_side_pkg::LTR_SNOOP_VAL_HI:msg_side_pkg::LTR_SNOOP_VAL_LO];
                m[msg_side_pkg::LTR_NOSNP_REQ] = d[msg_side_pkg::LTR_NOSNP_REQ];
                m[msg_side_pkg::LTR_NOSNP_SCL_HI:msg_side_pkg::LTR_NOSNP_SCL_LO] =
                    d[msg_side_pkg::LTR_NOSNP_SCL_HI:msg_side_pkg::LTR_NOSNP_SCL_LO];
                m[msg_side_pkg::LTR_NOSNP_VAL_HI:0] = d[msg_side_pkg::LTR_NOSNP_VAL_HI:0];
            end
            msg_side_pkg::TX_OBFF: m[msg_side_pkg::OBFF_CODE_HI:0] =
                d[msg_side_pkg::OBFF_CODE_HI:0];
            msg_side_pkg::TX_SSPL: m[msg_side_pkg::SSPL_HI:0] = d[msg_side_pkg::SSPL_HI:0];
            msg_side_pkg::TX_PME: begin
                m[msg_side_pkg::PME_PF_HI:0] = d[msg_side_pkg::PME_PF_HI:0];
                m[msg_side_pkg::PME_VF_HI:msg_side_pkg::PME_VF_LO] =
                    d[msg_side_pkg::PME_VF_HI:msg_side_pkg::PME_VF_LO];
            end
            default: m = 32'h00000000;
        endcase
        return m;
    endfunction

    // next state: take, hold a fixed latency, then one done cycle
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        typ_next   = typ_reg;
        word_next  = word_reg;
        bad_next   = bad_reg;
        case (state_reg)
            T_IDLE: begin
                if (tx_req && enable) begin
                    typ_next   = tx_type;
                    word_next  = mask_fields(tx_type, tx_data);
                    bad_next   = tx_type[2];
                    cnt_next   = 2'(msg_side_pkg::TX_LAT_CYC - 1);
                    state_next = T_BUSY;
                end
            end
            T_BUSY: begin
                if (cnt_reg == 2'h0) state_next = T_DONE;
                else cnt_next = cnt_reg - 2'h1;
            end
            T_DONE: state_next = T_IDLE;
            default: state_next = T_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= T_IDLE;
            cnt_reg   <= 2'h0;
            typ_reg   <= 3'h0;
            word_reg  <= 32'h00000000;
            bad_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            typ_reg   <= typ_next;
            word_reg  <= word_next;
            bad_reg   <= bad_next;
        end
    end

    assign tx_done   = (state_reg == T_DONE);
    assign sent      = tx_done && !bad_reg;
    assign bad_type  = tx_done && bad_reg;
    assign last_type = typ_reg;
    assign last_word = word_reg;

    a_tx_done_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_done |=> !tx_done)
        else $error("done longer than one cycle");
    a_tx_done_lat: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == T_IDLE && tx_req && enable) |-> ##3 tx_done)
        else $error("done latency wrong");
    a_tx_bad_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == T_IDLE && tx_req && enable && tx_type[2]) |-> ##3 bad_type)
        else $error("reserved code not flagged");
endmodule // tx_msg_engine
`default_nettype wire

//--- src/msg_side_channel.sv
// message side channel: received-message delivery and transmit requests,
// with an axi4-lite register port and one level interrupt
// assumes aclk is the core user clock; aresetn synchronous active low
//
// Functional notes
// - a received message raises the arrival flag for one or more back-to-back cycles.
// - how many cycles the arrival flag stays up is set by the byte count field [7:5] of the inject word.
// - message parameters go out on the 8-bit parameter bus, one byte per high cycle.
// - at least one low cycle separates two received messages.
// - the receive indication works only when the build-time enable attribute is set.
// - while arrival is high a 5-bit kind output names the message type.
// - type 0 is LTR, 1 OBFF, 2 slot power limit, 3 PM_PME; 4 to 7 are reserved.
// - for LTR, bit 31 is snoop requirement, 28:26 snoop scale, 25:16 snoop value.
// - for LTR, bit 15 is no-snoop requirement, 12:10 its scale, 9:0 its value.
// - for OBFF, bits 3:0 carry the OBFF code.
// - for slot power limit, bits 9:0 carry scale then value.
// - for PM_PME, bits 1:0 flag PF1/PF0 and bits 9:4 flag VF5 to VF0, several at once.
// - after a completed request done pulses high for exactly one cycle.
`timescale 1ns/100ps
`default_nettype none
module msg_side_channel #(
    parameter bit rx_side_channel_enable_attr = 1'b1,
    parameter int unsigned MAX_BYTES = 3
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // received message side
    output logic             msg_received,
    output logic [7:0]       msg_received_data,
    output logic [4:0]       msg_received_type,
    // transmit message side
    input  wire logic        msg_transmit,
    input  wire logic [2:0]  msg_transmit_type,
    input  wire logic [31:0] msg_transmit_data,
    output logic             msg_transmit_done,
    // interrupt
    output logic             irq
);
    localparam int unsigned SW = msg_side_pkg::ST_WIDTH;

    logic [1:0]    ctrl_reg, ctrl_next;
    logic [SW-1:0] stat_reg, stat_next;
    logic [SW-1:0] mask_reg, mask_next;
    logic [31:0]   inj_reg, inj_next;
    logic          inj_pend_reg, inj_pend_next;
    logic          aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
    logic [7:0]    awa_reg, awa_next;
    logic [31:0]   wd_reg, wd_next;
    logic [3:0]    ws_reg, ws_next;
    logic [1:0]    bresp_reg, bresp_next;
    logic          r_reg, r_next;
    logic [31:0]   rd_reg, rd_next;
    logic [1:0]    rresp_reg, rresp_next;
    logic [7:0]    rx_last_reg, rx_last_next;

    logic          rx_idle, rx_arr, tx_sent, tx_bad;
    logic [2:0]    tx_last_type;
    logic [31:0]   tx_last_word;
    logic          rx_go, do_wr;

    // merge a write word into a register under its byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction

    // only word-aligned known offsets are mapped
    function automatic logic mapped(input logic [7:0] a);
        return (a == msg_side_pkg::OFS_CTRL) || (a == msg_side_pkg::OFS_STATUS) ||
               (a == msg_side_pkg::OFS_MASK) || (a == msg_side_pkg::OFS_RX_INJECT) ||
               (a == msg_side_pkg::OFS_TX_LAST) || (a == msg_side_pkg::OFS_TX_DATA) ||
               (a == msg_side_pkg::OFS_RX_LAST);
    endfunction

    // receive path: link-side decoded message enters via the inject register
    assign rx_go = inj_pend_reg && rx_idle && rx_side_channel_enable_attr
                   && ctrl_reg[msg_side_pkg::CTRL_RX_EN];

    rx_msg_deliver #(
        .NBYTES    (MAX_BYTES)
    ) u_rx (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (rx_go),
        .msg_type  (inj_reg[4:0]),
        .msg_cnt   (inj_reg[msg_side_pkg::INJ_CNT_HI:msg_side_pkg::INJ_CNT_LO]),
        .msg_bytes (inj_reg[31:msg_side_pkg::INJ_BYTE_LO]),
        .idle      (rx_idle),
        .msg_arrived (rx_arr),
        .msg_param (msg_received_data),
        .msg_kind  (msg_received_type)
    );
    assign msg_received = rx_arr && rx_side_channel_enable_attr;

    tx_msg_engine u_tx (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .enable    (ctrl_reg[msg_side_pkg::CTRL_TX_EN]),
        .tx_req    (msg_transmit),
        .tx_type   (msg_transmit_type),
        .tx_data   (msg_transmit_data),
        .tx_done   (msg_transmit_done),
        .sent      (tx_sent),
        .bad_type  (tx_bad),
        .last_type (tx_last_type),
        .last_word (tx_last_word)
    );

    assign do_wr = aw_reg && w_reg && !b_reg;

    // bus slave, registers and sticky status
    always_comb begin
        ctrl_next     = ctrl_reg;
        mask_next     = mask_reg;
        inj_next      = inj_reg;
        inj_pend_next = inj_pend_reg && !rx_go;
        aw_next       = aw_reg;
        w_next        = w_reg;
        b_next        = b_reg;
        awa_next      = awa_reg;
        wd_next       = wd_reg;
        ws_next       = ws_reg;
        bresp_next    = bresp_reg;
        r_next        = r_reg;
        rd_next       = rd_reg;
        rresp_next    = rresp_reg;
        rx_last_next  = rx_go ? inj_reg[7:0] : rx_last_reg;
        stat_next     = stat_reg;
        if (s_axi_awvalid && !aw_reg) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_reg) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (do_wr) begin
            b_next     = 1'b1;
            bresp_next = mapped(awa_reg) ? msg_side_pkg::RESP_OKAY : msg_side_pkg::RESP_SLVERR;
            case (awa_reg)
                msg_side_pkg::OFS_CTRL: ctrl_next = 2'(merge({30'h0, ctrl_reg}, wd_reg, ws_reg));
                msg_side_pkg::OFS_STATUS:
                    if (ws_reg[0]) stat_next = stat_reg & ~wd_reg[SW-1:0]; // write one to clear
                msg_side_pkg::OFS_MASK:
                    mask_next = SW'(merge({29'h0, mask_reg}, wd_reg, ws_reg));
                msg_side_pkg::OFS_RX_INJECT: begin
                    inj_next      = merge(inj_reg, wd_reg, ws_reg);
                    inj_pend_next = 1'b1;
                end
                default: ;
            endcase
        end
        if (b_reg && s_axi_bready) begin
            b_next  = 1'b0;
            aw_next = 1'b0;
            w_next  = 1'b0;
        end
        // events win over a same-cycle clear
        if (rx_go) stat_next[msg_side_pkg::ST_RX_DONE] = 1'b1;
        if (tx_sent) stat_next[msg_side_pkg::ST_TX_DONE] = 1'b1;
        if (tx_bad) stat_next[msg_side_pkg::ST_TX_BAD] = 1'b1;
        if (s_axi_arvalid && !r_reg) begin
            r_next     = 1'b1;
            rresp_next = mapped(s_axi_araddr) ? msg_side_pkg::RESP_OKAY
                                              : msg_side_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                msg_side_pkg::OFS_CTRL:      rd_next = {30'h0, ctrl_reg};
                msg_side_pkg::OFS_STATUS:    rd_next = {29'h0, stat_reg};
                msg_side_pkg::OFS_MASK:      rd_next = {29'h0, mask_reg};
                msg_side_pkg::OFS_RX_INJECT: rd_next = inj_reg;
                msg_side_pkg::OFS_TX_LAST:   rd_next = {29'h0, tx_last_type};
                msg_side_pkg::OFS_TX_DATA:   rd_next = tx_last_word;
                msg_side_pkg::OFS_RX_LAST:   rd_next = {24'h0, rx_last_reg};
                default:                     rd_next = 32'h00000000;
            endcase
        end else if (r_reg && s_axi_rready) begin
            r_next = 1'b0;
        end
    end

    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg     <= 2'h3;
            stat_reg     <= '0;
            mask_reg     <= '0;
            inj_reg      <= 32'h00000000;
            inj_pend_reg <= 1'b0;
            aw_reg       <= 1'b0;
            w_reg        <= 1'b0;
            b_reg        <= 1'b0;
            awa_reg      <= 8'h00;
            wd_reg       <= 32'h00000000;
            ws_reg       <= 4'h0;
            bresp_reg    <= 2'h0;
            r_reg        <= 1'b0;
            rd_reg       <= 32'h00000000;
            rresp_reg    <= 2'h0;
            rx_last_reg  <= 8'h00;
        end else begin
            ctrl_reg     <= ctrl_next;
            stat_reg     <= stat_next;
            mask_reg     <= mask_next;
            inj_reg      <= inj_next;
            inj_pend_reg <= inj_pend_next;
            aw_reg       <= aw_next;
            w_reg        <= w_next;
            b_reg        <= b_next;
            awa_reg      <= awa_next;
            wd_reg       <= wd_next;
            ws_reg       <= ws_next;
            bresp_reg    <= bresp_next;
            r_reg        <= r_next;
            rd_reg       <= rd_next;
            rresp_reg    <= rresp_next;
            rx_last_reg  <= rx_last_next;
        end
    end

    // bus outputs
    assign s_axi_awready = !aw_reg;
    assign s_axi_wready  = !w_reg;
    assign s_axi_bvalid  = b_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !r_reg;
    assign s_axi_rvalid  = r_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = |(stat_reg & mask_reg);

    a_rx_kind_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (msg_received && $past(msg_received)) |-> $stable(msg_received_type))
        else $error("kind changed inside a message");
    a_rx_attr_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !rx_side_channel_enable_attr |-> !msg_received)
        else $error("arrival while attribute clear");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(stat_reg & mask_reg) && !do_wr) |=> irq)
        else $error("irq dropped without a clear");
    a_tx_status_set: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_sent |=> stat_reg[msg_side_pkg::ST_TX_DONE])
        else $error("tx done status not set");
    a_rx_first_byte: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_go |=> msg_received_data == $past(inj_reg[15:8]))
        else $error("first parameter byte wrong");
endmodule // msg_side_channel
`default_nettype wire

//--- verif/user_app_model.sv
// user application model on the transmit side
// assumes go is a one-cycle pulse and done a one-cycle answer
`timescale 1ns/100ps
`default_nettype none
module user_app_model (
    // clock and command
    input  wire logic        aclk,
    input  wire logic        go,
    input  wire logic [2:0]  ttyp,
    input  wire logic [31:0] tdat,
    // transmit request
    output logic             msg_transmit,
    output logic [2:0]       msg_transmit_type,
    output logic [31:0]      msg_transmit_data,
    input  wire logic        msg_transmit_done
);
    initial {msg_transmit, msg_transmit_type, msg_transmit_data} = '0;
    // hold request until done, then drop it
    always @(posedge aclk) begin
        if (go && !msg_transmit) begin
            msg_transmit      <= 1'h1;
            msg_transmit_type <= ttyp;
            msg_transmit_data <= tdat;
        end else if (msg_transmit && msg_transmit_done) begin
            msg_transmit      <= 1'h0;
            msg_transmit_data <= ~msg_transmit_data;
        end
    end
endmodule // user_app_model
`default_nettype wire

//--- verif/tb_top.sv
// testbench: register bus, received delivery, transmit requests
// assumes the design package and the user application model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic aclk = 0, aresetn = 0, go = 0, irq, msg_received, msg_transmit, msg_transmit_done;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, msg_received_data, got[$];
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, msg_transmit_data, d, tdat = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [4:0]  msg_received_type, rtyp = '0;
    logic [2:0]  msg_transmit_type, ttyp = '0;
    int          err_count = 0, compares = 0, n;
    msg_side_channel u_msg_side_channel (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .msg_received, .msg_received_data,
        .msg_received_type, .msg_transmit, .msg_transmit_type, .msg_transmit_data,
        .msg_transmit_done, .irq);
    user_app_model u_user_app_model (.aclk, .go, .ttyp, .tdat, .msg_transmit,
        .msg_transmit_type, .msg_transmit_data, .msg_transmit_done);
    initial forever #50 aclk = ~aclk;
    // collect delivered bytes and check the kind
    always @(posedge aclk) if (msg_received) begin
        got.push_back(msg_received_data);
        chk("rx type", {27'h0, rtyp}, {27'h0, msg_received_type});
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo;
        err_count++;
        $display("ERROR wait expected answer seen none");
        test_done;
    endtask
    // one write, each channel released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        if (n == 50) tmo;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 50) tmo;
    endtask
    // fields kept for each transmit type
    function automatic logic [31:0] fmask(input int t);
        case (t)
            0: return 32'h9fff9fff;
            1: return 32'hf;
            2: return 32'h3ff;
            default: return 32'h3f3;
        endcase
    endfunction
    initial begin
        void'($urandom(32'ha4ee0eb7));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(msg_side_pkg::OFS_CTRL);
        chk("ctrl", 32'h3, d);
        rd(8'h1c);
        chk("unmapped", {30'h0, msg_side_pkg::RESP_SLVERR}, {d[29:0], r});
        wr(msg_side_pkg::OFS_MASK, 32'h7);
        chk("bresp", {30'h0, msg_side_pkg::RESP_OKAY}, {30'h0, r});
        for (int k = 0; k <= 3; k++) begin
            d = $urandom;
            rtyp = d[4:0];
            d[7:5] = k[2:0];
            got.delete();
            wr(msg_side_pkg::OFS_RX_INJECT, d);
            repeat (10) @(posedge aclk);
            chk("rx count", k + (k == 0), got.size());
            for (int i = 0; i < k + (k == 0); i++) chk("rx byte", {24'h0, d[8*i+8 +: 8]}, {24'h0, got[i]});
        end
        chk("irq", 32'h1, {31'h0, irq});
        wr(msg_side_pkg::OFS_STATUS, 32'h7);
        repeat (2) @(posedge aclk);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("rx test done");
        for (int t = 0; t < 8; t++) begin
            ttyp <= t[2:0];
            tdat <= $urandom;
            go <= 1'h1;
            @(posedge aclk);
            go <= 1'h0;
            for (n = 0; n < 20 && msg_transmit_done !== 1'h1; n++) @(posedge aclk);
            if (n == 20) tmo;
            @(posedge aclk);
            chk("done pulse", 32'h0, {31'h0, msg_transmit_done});
            rd(msg_side_pkg::OFS_STATUS);
            chk("bad type", {31'h0, t > 3}, {31'h0, d[2]});
            rd(msg_side_pkg::OFS_TX_DATA);
            if (t < 4) chk("tx data", tdat & fmask(t), d);
            wr(msg_side_pkg::OFS_STATUS, 32'h7);
        end
        $display("tx test done");
        test_done;
    end
endmodule // tb_top
`default_nettype wire
